//--- rtl/add_flags_unit.sv
// Purpose: Eight-bit adder with status flags
// Assumes: Operands stable in the process quarter
// Notes: Purely combinational; caller registers results
`timescale 1ns/1ps
`include "instruction_format_decoder_regs.svh"
module add_flags_unit (
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	output logic [7:0] sum,
	output logic [4:0] flags
);
	logic [8:0] wide;
	logic [4:0] low;

	always_comb begin
		wide = {1'b0, opA} + {1'b0, opB};
		low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
		sum = wide[7:0];
		flags = 5'h00;
		flags[`IFD_FLAG_C] = wide[8];
		flags[`IFD_FLAG_HC] = low[4];
		flags[`IFD_FLAG_Z] = (wide[7:0] == 8'h00);
		flags[`IFD_FLAG_OV] = (opA[7] == opB[7]) && (wide[7] != opA[7]);
		flags[`IFD_FLAG_N] = wide[7];
	end
endmodule : add_flags_unit

//--- rtl/instruction_format_decoder.sv
// Purpose: Decode and sequence 16-bit core instruction words
// Assumes: Fetch presents the next word each cycle end
// Notes: File data is read combinationally from the register file port
`timescale 1ns/1ps
`include "instruction_format_decoder_regs.svh"
module instruction_format_decoder #(
	parameter int PTR_WIDTH = 21,
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] fetchWord,
	input wire logic extendedEnable,
	input wire logic [7:0] fileReadData,
	input wire logic [7:0] tableReadData,
	input wire logic branchTaken,
	output logic fetchNext,
	output logic [ADDR_WIDTH-1:0] fileAddr,
	output logic fileWrite,
	output logic [7:0] fileWriteData,
	output logic [7:0] working_register,
	output logic [7:0] bank_select_register,
	output logic [ADDR_WIDTH-1:0] indirect_pointer_two,
	output logic [4:0] statusFlags,
	output logic [PTR_WIDTH-1:0] program_read_pointer,
	output logic [7:0] program_read_latch,
	output logic [ADDR_WIDTH-1:0] moveSource,
	output logic [ADDR_WIDTH-1:0] moveDest,
	output logic [19:0] literal20,
	output logic [1:0] pointerSelect,
	output logic [2:0] bitSelect,
	output logic [6:0] srcOffset,
	output logic [6:0] dstOffset,
	output logic fastMode,
	output logic shadowSave,
	output logic shadowRestore,
	output logic twoWordActive,
	output logic flushActive,
	output instruction_format_decoder_pkg::quarter_t phase
);
	logic cycleEnd;
	logic [15:0] instr;
	logic [15:0] next_instr;
	logic pendingSecond;
	logic next_pendingSecond;
	logic flush;
	logic next_flush;
	logic [15:0] firstWord;
	logic [15:0] next_firstWord;
	logic [7:0] next_working;
	logic [4:0] next_flags;
	logic [PTR_WIDTH-1:0] next_ptr;
	logic [7:0] next_latch;
	logic [ADDR_WIDTH-1:0] next_fileAddr;
	logic [7:0] sumOut;
	logic [4:0] sumFlags;
	logic [7:0] addOperand;
	logic isAddFile;
	logic isAddLit;
	logic isTable;
	logic isTwoWord;
	logic isSecond;
	logic isBitOp;
	logic isReturn;
	logic isCall;
	logic indexed;
	logic altersFlow;
	logic [1:0] tblMode;
	logic [ADDR_WIDTH-1:0] next_moveSource;
	logic [ADDR_WIDTH-1:0] next_moveDest;
	logic [19:0] next_literal;

	// ----------------------------------------
	// Sequencing and arithmetic helpers
	// ----------------------------------------
	quarter_sequencer u_seq (
		.clock(clock),
		.rst(rst),
		.phase(phase),
		.cycleEnd(cycleEnd)
	);

	add_flags_unit u_add (
		.opA(working_register),
		.opB(addOperand),
		.sum(sumOut),
		.flags(sumFlags)
	);

	// ----------------------------------------
	// Instruction classification
	// ----------------------------------------
	// four two-word formats
	always_comb begin
		isAddFile = (instr[15:10] == `IFD_OP_ADD_FILE);
		isAddLit = (instr[15:8] == `IFD_OP_ADD_LIT);
		isTable = (instr[15:4] == `IFD_OP_TBL) && instr[3];
		isTwoWord = (instr[15:12] == `IFD_OP_MOVFF)
			|| (instr[15:8] == `IFD_OP_GOTO)
			|| (instr[15:9] == `IFD_OP_CALL)
			|| (instr[15:8] == `IFD_OP_LFSR);
		isCall = (instr[15:9] == `IFD_OP_CALL);
		isReturn = (instr[15:1] == `IFD_OP_RETURN);
		isBitOp = (instr[15:12] == `IFD_OP_BSF);
		isSecond = (instr[15:12] == `IFD_SECOND_NIBBLE);
		altersFlow = (instr[15:11] == `IFD_OP_BRA) || isReturn
			|| ((instr[15:12] == `IFD_OP_BTFSC) && branchTaken);
		indexed = extendedEnable && !instr[`IFD_A_BIT]
			&& (instr[7:0] <= `IFD_INDEX_LIMIT)
			&& !isAddLit && !isTwoWord && !isSecond;
		tblMode = instr[1:0];
	end

	// ----------------------------------------
	// Operand address formation
	// ----------------------------------------
	always_comb begin
		next_fileAddr = fileAddr;
		if (indexed) begin
			next_fileAddr = indirect_pointer_two
				+ {{(ADDR_WIDTH-8){1'b0}}, instr[7:0]};
		end else if (instr[`IFD_A_BIT]) begin
			next_fileAddr = {bank_select_register[ADDR_WIDTH-9:0],
				instr[7:0]};
		end else begin
			next_fileAddr = {{(ADDR_WIDTH-8){instr[7]}}, instr[7:0]};
		end
	end

	assign addOperand = isAddLit ? instr[7:0] : fileReadData;

	// ----------------------------------------
	// Pipeline state: word, pending second, flush
	// ----------------------------------------
	always_comb begin
		next_instr = instr;
		next_pendingSecond = pendingSecond;
		next_flush = flush;
		next_firstWord = firstWord;
		next_moveSource = moveSource;
		next_moveDest = moveDest;
		next_literal = literal20;
		if (cycleEnd) begin
			next_flush = 1'b0;
			next_pendingSecond = 1'b0;
			if (pendingSecond) begin
				next_moveSource = firstWord[11:0];
				next_moveDest = instr[11:0];
				next_literal = {instr[11:0], firstWord[7:0]};
				next_flush = (firstWord[15:12] != `IFD_OP_MOVFF)
					&& (firstWord[15:8] != `IFD_OP_LFSR);
				// Moves and pointer loads keep the prefetched word
				next_instr = next_flush ? `IFD_NOP_WORD : fetchWord;
			end else if (flush) begin
				next_instr = fetchWord;
			end else if (isTwoWord) begin
				next_pendingSecond = 1'b1;
				next_firstWord = instr;
				next_instr = fetchWord;
			end else if (altersFlow) begin
				next_flush = 1'b1;
				next_instr = `IFD_NOP_WORD;
			end else begin
				next_instr = fetchWord;
				next_literal = isAddLit ? {12'h000, instr[7:0]}
					: {8'h00, instr[11:0]};
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			instr <= `IFD_NOP_WORD;
			pendingSecond <= 1'b0;
			flush <= 1'b0;
			firstWord <= `IFD_NOP_WORD;
			moveSource <= '0;
			moveDest <= '0;
			literal20 <= 20'h00000;
		end else begin
			instr <= next_instr;
			pendingSecond <= next_pendingSecond;
			flush <= next_flush;
			firstWord <= next_firstWord;
			moveSource <= next_moveSource;
			moveDest <= next_moveDest;
			literal20 <= next_literal;
		end
	end

	// ----------------------------------------
	// Execute state per quarter
	// ----------------------------------------
	always_comb begin
		next_working = working_register;
		next_flags = statusFlags;
		next_ptr = program_read_pointer;
		next_latch = program_read_latch;
		fileWrite = 1'b0;
		fileWriteData = sumOut;
		if (phase == instruction_format_decoder_pkg::Q4 && !pendingSecond
			&& !flush && !isSecond) begin
			if (isAddFile || isAddLit) begin
				next_flags = sumFlags;
				if (isAddFile && instr[`IFD_D_BIT]) begin
					fileWrite = 1'b1;
				end else begin
					next_working = sumOut;
				end
			end
			if (isTable) begin
				unique case (tblMode)
					2'h0: next_latch = tableReadData;
					2'h1: begin
						next_latch = tableReadData;
						next_ptr = program_read_pointer + 1'b1;
					end
					2'h2: begin
						next_latch = tableReadData;
						next_ptr = program_read_pointer - 1'b1;
					end
					2'h3: next_ptr = program_read_pointer + 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			working_register <= 8'h00;
			statusFlags <= 5'h00;
			program_read_pointer <= '0;
			program_read_latch <= 8'h00;
			fileAddr <= '0;
		end else begin
			working_register <= next_working;
			statusFlags <= next_flags;
			program_read_pointer <= next_ptr;
			program_read_latch <= next_latch;
			if (phase == instruction_format_decoder_pkg::Q1) begin
				fileAddr <= next_fileAddr;
			end
		end
	end

	// Bank select and pointer two are never loaded; they hold their reset value
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bank_select_register <= 8'h00;
			indirect_pointer_two <= '0;
		end else begin
			bank_select_register <= bank_select_register;
			indirect_pointer_two <= indirect_pointer_two;
		end
	end

	// ----------------------------------------
	// Field outputs
	// ----------------------------------------
	// bit number field
	assign bitSelect = isBitOp ? instr[11:9] : 3'h0;
	assign pointerSelect = instr[5:4];
	assign srcOffset = firstWord[6:0];
	assign dstOffset = instr[6:0];
	assign fastMode = (isCall || isReturn) && instr[`IFD_S_BIT];
	assign shadowSave = fastMode && isCall && cycleEnd;
	assign shadowRestore = fastMode && isReturn && cycleEnd;
	assign fetchNext = cycleEnd;
	assign twoWordActive = pendingSecond;
	assign flushActive = flush;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_flow_flush;
		@(posedge clock) disable iff (rst)
		cycleEnd && !pendingSecond && !flush && !isTwoWord && altersFlow
		|=> flush && instr == `IFD_NOP_WORD;
	endproperty
	a_flow_flush: assert property (p_flow_flush)
		else $error("branch did not flush prefetched word");

	property p_two_cycles;
		@(posedge clock) disable iff (rst)
		cycleEnd && !pendingSecond && !flush && isTwoWord
		|=> pendingSecond [*4] ##1 !pendingSecond;
	endproperty
	a_two_cycles: assert property (p_two_cycles)
		else $error("two-word instruction not two cycles");

	property p_dest_file;
		@(posedge clock) disable iff (rst)
		fileWrite |-> phase == instruction_format_decoder_pkg::Q4
			&& isAddFile && instr[`IFD_D_BIT]
			&& fileWriteData == sumOut;
	endproperty
	a_dest_file: assert property (p_dest_file)
		else $error("file write without destination bit");

	property p_dest_working;
		@(posedge clock) disable iff (rst)
		phase == instruction_format_decoder_pkg::Q4 && isAddFile
		&& !instr[`IFD_D_BIT] && !pendingSecond && !flush
		|=> working_register == $past(sumOut);
	endproperty
	a_dest_working: assert property (p_dest_working)
		else $error("working register not updated");

	property p_second_nop;
		@(posedge clock) disable iff (rst)
		isSecond && !pendingSecond |=> $stable(working_register);
	endproperty
	a_second_nop: assert property (p_second_nop)
		else $error("lone second word changed state");

	property p_postinc;
		@(posedge clock) disable iff (rst)
		phase == instruction_format_decoder_pkg::Q4 && isTable
		&& tblMode == 2'h1 && !pendingSecond && !flush
		|=> program_read_pointer == $past(program_read_pointer) + 1'b1;
	endproperty
	a_postinc: assert property (p_postinc)
		else $error("post-increment wrong");

	property p_bank;
		@(posedge clock) disable iff (rst)
		phase == instruction_format_decoder_pkg::Q1 && !indexed
		&& instr[`IFD_A_BIT]
		|=> fileAddr[7:0] == $past(instr[7:0]);
	endproperty
	a_bank: assert property (p_bank)
		else $error("banked address wrong");

	property p_indexed;
		@(posedge clock) disable iff (rst)
		phase == instruction_format_decoder_pkg::Q1 && indexed
		|=> fileAddr == $past(indirect_pointer_two)
			+ {{(ADDR_WIDTH-8){1'b0}}, $past(instr[7:0])};
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("indexed address wrong");
endmodule : instruction_format_decoder

//--- rtl/instruction_format_decoder_pkg.sv
// Purpose: Types for the instruction format decoder
// Assumes: Included constants header supplies numbers
// Notes: Quarter phase and pointer mode enums
package instruction_format_decoder_pkg;
	typedef enum logic [1:0] {
		Q1 = 2'h0,
		Q2 = 2'h1,
		Q3 = 2'h3,
		Q4 = 2'h2
	} quarter_t;
	typedef enum logic [1:0] {
		PTR_HOLD = 2'h0,
		PTR_POSTINC = 2'h1,
		PTR_POSTDEC = 2'h2,
		PTR_PREINC = 2'h3
	} ptr_mode_t;
endpackage : instruction_format_decoder_pkg

//--- rtl/instruction_format_decoder_regs.svh
// Purpose: Constants for the instruction format decoder
// Assumes: 16-bit program words, 4 oscillator periods per instruction cycle
// Notes: Field positions, opcodes and flag positions are named here
// Function
// - Most instructions one word, four take two.
// - Second word top nibble ones, alone NOP.
// - Single word one cycle, two if branching.
// - Two-word instructions take two cycles; goto and call add a third flush cycle here.
// - Instruction cycle is four oscillator periods.
// - Destination bit picks working or file register.
// - Access bit picks access bank or bank select.
// - Three-bit field picks bit zero to seven.
// - Register field is address or pointer selector.
// - Register moves carry twelve-bit source, destination.
// - Literals are eight, twelve or twenty bits.
// - Table ops apply one of four pointer modes.
// - Read pointer 21 bits, latch eight bits.
// - Fast bit uses shadow registers for call/return.
// - Indirect offset fields are seven bits wide.
// - Add to file sums, routes, updates five flags.
// - Extended set, access clear, f<=95 uses indexing.
// - Indexed add uses pointer two plus offset.
`ifndef INSTRUCTION_FORMAT_DECODER_REGS_SVH
`define INSTRUCTION_FORMAT_DECODER_REGS_SVH

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IFD_D_BIT 9
`define IFD_A_BIT 8
`define IFD_S_BIT 0
`define IFD_INDEX_LIMIT 8'h5F
`define IFD_NOP_WORD 16'h0000
`define IFD_SECOND_NIBBLE 4'hF

// ----------------------------------------
// Opcode patterns (upper bits)
// ----------------------------------------
`define IFD_OP_ADD_FILE 6'h09
`define IFD_OP_ADD_LIT 8'h0F
`define IFD_OP_MOVFF 4'hC
`define IFD_OP_GOTO 8'hEF
`define IFD_OP_CALL 7'h76
`define IFD_OP_LFSR 8'hEE
`define IFD_OP_BSF 4'h8
`define IFD_OP_SETF 7'h34
`define IFD_OP_TBL 12'h000
`define IFD_OP_RETURN 15'h0009
`define IFD_OP_BRA 5'h1A
`define IFD_OP_BTFSC 4'hB

// ----------------------------------------
// Flag positions in the status byte
// ----------------------------------------
`define IFD_FLAG_C 0
`define IFD_FLAG_HC 1
`define IFD_FLAG_Z 2
`define IFD_FLAG_OV 3
`define IFD_FLAG_N 4

`define IFD_QUARTERS 2'h3

`endif

//--- rtl/quarter_sequencer.sv
// Purpose: Splits the oscillator into four-period instruction cycles
// Assumes: One oscillator period per clock edge
// Notes: Gray sequence keeps phase decode glitch free
`timescale 1ns/1ps
`include "instruction_format_decoder_regs.svh"
module quarter_sequencer (
	input wire logic clock,
	input wire logic rst,
	output instruction_format_decoder_pkg::quarter_t phase,
	output logic cycleEnd
);
	instruction_format_decoder_pkg::quarter_t next_phase;

	// ----------------------------------------
	// Phase stepping
	// ----------------------------------------
	// four periods per cycle
	always_comb begin
		unique case (phase)
			instruction_format_decoder_pkg::Q1:
				next_phase = instruction_format_decoder_pkg::Q2;
			instruction_format_decoder_pkg::Q2:
				next_phase = instruction_format_decoder_pkg::Q3;
			instruction_format_decoder_pkg::Q3:
				next_phase = instruction_format_decoder_pkg::Q4;
			instruction_format_decoder_pkg::Q4:
				next_phase = instruction_format_decoder_pkg::Q1;
		endcase
	end

	// Phase register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase <= instruction_format_decoder_pkg::Q1;
		end else begin
			phase <= next_phase;
		end
	end

	assign cycleEnd = (phase == instruction_format_decoder_pkg::Q4);

	property p_cycle_four;
		@(posedge clock) disable iff (rst)
		cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd;
	endproperty
	a_cycle_four: assert property (p_cycle_four)
		else $error("instruction cycle is not four periods");
endmodule : quarter_sequencer

//--- tb/program_file_model.sv
// Purpose: Program memory and data file seen by the decoder
// Assumes: One word taken per instruction cycle on fetchNext
// Notes: Reads are combinational, writes land at the Q4 edge
`timescale 1ns/1ps
module program_file_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic fetchNext,
	input wire logic [11:0] fileAddr,
	input wire logic fileWrite,
	input wire logic [7:0] fileWriteData,
	input wire logic [20:0] readPointer,
	output logic [15:0] fetchWord,
	output logic [7:0] fileReadData,
	output logic [7:0] tableReadData
);
	logic [15:0] prog [0:63];
	logic [7:0] fileMem [0:4095];
	logic [5:0] pc;

	// ----------------------------------------
	// Fetch side
	// ----------------------------------------
	// Advances on every fetch strobe, so a flushed word is still consumed
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pc <= 6'h00;
		end else if (fetchNext) begin
			pc <= pc + 6'h01;
		end
	end
	assign fetchWord = prog[pc];

	// ----------------------------------------
	// Data file and table bytes
	// ----------------------------------------
	// Write at the edge that ends the cycle
	always @(posedge clock) begin
		if (fileWrite) begin
			fileMem[fileAddr] <= fileWriteData;
		end
	end
	assign fileReadData = fileMem[fileAddr];
	// Pattern of the pointer, so a stale pointer shows in the latch
	assign tableReadData = readPointer[7:0] ^ 8'h5C;
endmodule : program_file_model

//--- tb/test_instruction_format_decoder.sv
// Purpose: Self-checking bench for the instruction format decoder
// Assumes: Inputs change on the falling edge of clock
// Notes: Each scenario resets, loads a program and steps cycles
`timescale 1ns/1ps
module test_instruction_format_decoder;
	logic clock, rst, extendedEnable, branchTaken, fetchNext;
	logic fileWrite, shadowSave, shadowRestore, twoWordActive;
	logic flushActive;
	logic [15:0] fetchWord;
	logic [7:0] fileReadData, tableReadData, fileWriteData, workReg, latch;
	logic [11:0] fileAddr, moveSource, moveDest;
	logic [4:0] statusFlags;
	logic [20:0] readPtr;
	logic [19:0] literal20;
	logic [1:0] pointerSelect;
	logic [2:0] bitSelect;
	instruction_format_decoder_pkg::quarter_t phase;
	int badCount, checkCount, restoreCount;
	logic sawSave, sawFlush, sawTwo;

	instruction_format_decoder DUT (
		.clock(clock), .rst(rst), .fetchWord(fetchWord),
		.extendedEnable(extendedEnable), .fileReadData(fileReadData),
		.tableReadData(tableReadData), .branchTaken(branchTaken),
		.fetchNext(fetchNext), .fileAddr(fileAddr), .fileWrite(fileWrite),
		.fileWriteData(fileWriteData), .working_register(workReg),
		.bank_select_register(), .indirect_pointer_two(),
		.statusFlags(statusFlags), .program_read_pointer(readPtr),
		.program_read_latch(latch), .moveSource(moveSource),
		.moveDest(moveDest), .literal20(literal20),
		.pointerSelect(pointerSelect), .bitSelect(bitSelect),
		.srcOffset(), .dstOffset(), .fastMode(),
		.shadowSave(shadowSave), .shadowRestore(shadowRestore),
		.twoWordActive(twoWordActive), .flushActive(flushActive),
		.phase(phase)
	);
	program_file_model model (
		.clock(clock), .rst(rst), .fetchNext(fetchNext),
		.fileAddr(fileAddr), .fileWrite(fileWrite),
		.fileWriteData(fileWriteData), .readPointer(readPtr),
		.fetchWord(fetchWord), .fileReadData(fileReadData),
		.tableReadData(tableReadData)
	);

	// ----------------------------------------
	// Clock, watchdog and sticky monitors
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Pulses may fall between samples, so they are latched here
	// Cleared by reset only, so each scenario starts from nothing seen
	always @(posedge clock) begin
		if (rst === 1'b1) begin
			sawSave <= 1'b0;
			sawFlush <= 1'b0;
			sawTwo <= 1'b0;
			restoreCount <= 0;
		end else begin
			if (shadowSave === 1'b1) sawSave <= 1'b1;
			if (shadowRestore === 1'b1) restoreCount <= restoreCount + 1;
			if (flushActive === 1'b1) sawFlush <= 1'b1;
			if (twoWordActive === 1'b1) sawTwo <= 1'b1;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// Reset held five cycles while the program is loaded
	task automatic restart(input logic [15:0] w [$]);
		@(negedge clock);
		rst = 1'b1;
		for (int i = 0; i < 64; i++) begin
			model.prog[i] = (i < w.size()) ? w[i] : 16'h0000;
		end
		model.fileMem[12'h020] = 8'hC2;
		repeat (5) @(negedge clock);
		rst = 1'b0;
	endtask : restart

	// Passes n Q4 edges; a missing fetch strobe is a mismatch
	task automatic step(input int n);
		int k;
		repeat (n) begin
			k = 0;
			while (fetchNext !== 1'b1 && k < 8) begin
				@(negedge clock);
				k++;
			end
			if (k >= 8) begin
				badCount++;
				$display("[FAIL] %0t no fetch strobe", $time);
			end
			@(negedge clock);
		end
	endtask : step

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// quarter sequence
	task automatic testQuarters();
		instruction_format_decoder_pkg::quarter_t q [4];
		q = '{instruction_format_decoder_pkg::Q1,
			instruction_format_decoder_pkg::Q2,
			instruction_format_decoder_pkg::Q3,
			instruction_format_decoder_pkg::Q4};
		restart('{16'h0000});
		for (int i = 0; i < 8; i++) begin
			chk(phase, q[i % 4]);
			chk(fetchNext, (i % 4) == 3);
			@(negedge clock);
		end
	endtask : testQuarters

	task automatic testAddLiteral();
		restart('{16'h0F15, 16'h0FF0, 16'h0F7B, 16'h0F80});
		step(4);
		chk(workReg, 8'h80);
		chk(statusFlags, 5'h1A);
		step(1);
		chk(workReg, 8'h00);
		chk(statusFlags, 5'h0D);
	endtask : testAddLiteral

	task automatic testAddFile();
		extendedEnable = 1'b1;
		restart('{16'h0F17, 16'h2720, 16'h2420});
		step(3);
		chk(model.fileMem[12'h020], 8'hD9);
		chk(workReg, 8'h17);
		chk(fileAddr, 12'h020);
		chk(statusFlags, 5'h10);
		step(1);
		chk(workReg, 8'hF0);
		chk(model.fileMem[12'h020], 8'hD9);
		chk(statusFlags, 5'h12);
		extendedEnable = 1'b0;
	endtask : testAddFile

	task automatic testTable();
		restart('{16'h0009, 16'h000A, 16'h000B, 16'h0008});
		step(2);
		chk(readPtr, 21'h000001);
		chk(latch, 8'h5C);
		step(1);
		chk(readPtr, 21'h000000);
		chk(latch, 8'h5D);
		step(1);
		chk(readPtr, 21'h000001);
		step(1);
		chk(latch, 8'h5D);
		chk(readPtr, 21'h000001);
	endtask : testTable

	task automatic testTwoWord();
		restart('{16'hC123, 16'hF456, 16'hF000, 16'hEF12, 16'hF345,
			16'h0F01, 16'h0F02});
		step(3);
		chk(sawTwo, 1'b1);
		chk(moveSource, 12'h123);
		chk(moveDest, 12'h456);
		step(1);
		chk(workReg, 8'h00);
		step(2);
		chk(literal20, 20'h34512);
		step(2);
		chk(sawFlush, 1'b1);
		chk(workReg, 8'h02);
	endtask : testTwoWord

	task automatic testFlow();
		branchTaken = 1'b1;
		restart('{16'hB000, 16'h0F01, 16'h0F02, 16'hD000, 16'h0F04,
			16'h0F08, 16'hB000, 16'h0F10});
		step(4);
		chk(workReg, 8'h02);
		step(3);
		chk(workReg, 8'h0A);
		branchTaken = 1'b0;
		step(2);
		chk(workReg, 8'h1A);
	endtask : testFlow

	task automatic testFast();
		// Fast bit set in both candidate positions of the call word
		restart('{16'hED35, 16'hF000, 16'h0000, 16'h0013, 16'h0000,
			16'h0012});
		step(6);
		chk(sawSave, 1'b1);
		chk(restoreCount, 32'h00000001);
		step(2);
		chk(restoreCount, 32'h00000001);
	endtask : testFast

	task automatic testFields();
		restart('{16'h8E20, 16'h8220, 16'hEE20, 16'hF0AB});
		step(1);
		chk(bitSelect, 3'h7);
		step(1);
		chk(bitSelect, 3'h1);
		step(1);
		chk(pointerSelect, 2'h2);
		chk(bitSelect, 3'h0);
	endtask : testFields

	task automatic giveVerdict();
		$display("Checks %0d, mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : giveVerdict

	initial begin
		rst = 1'b1;
		extendedEnable = 1'b0;
		branchTaken = 1'b0;
		badCount = 0;
		checkCount = 0;
		fork
			begin
				testQuarters();
				testAddLiteral();
				testAddFile();
				testTable();
				testTwoWord();
				testFlow();
				testFast();
				testFields();
			end
			begin
				// Ceiling far above the few hundred cycles used
				repeat (3000) @(posedge clock);
				badCount++;
				$display("[FAIL] %0t cycle limit reached", $time);
			end
		join_any
		giveVerdict();
	end
endmodule : test_instruction_format_decoder
